// >>> rtl/mpdc_top.sv
// Power and SPI debug control register bank on AHB-Lite
//
// Contract
// - Reserved bits ignore writes and read back as zero.
// - Slot drive enable clear leaves all assigned serial interrupt slots undriven.
// - Slot drive enable set drives each assigned slot with its interrupt state.
// - Loopback routes SPI output into SPI input; data output stays active.
// - Power control register clears only on main power-on reset.
// - I/O bank switch enable is S0 OR sleep-power-keep bit.
// - Keep bit set keeps I/O bank powered and configured in sleep.
// - Card switch enable is S0 OR NOT sleep-power-off bit.
// - Writing the SPI top data byte starts a transfer, also in loopback.
//
// The address map and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
module mpdc_top (
    input  wire logic                           hclk,
    input  wire logic                           hresetn,
    input  wire logic                           plat_resetn,
    input  wire logic                           hsel,
    input  wire logic [31:0]                    haddr,
    input  wire logic [1:0]                     htrans,
    input  wire logic                           hwrite,
    input  wire logic [2:0]                     hsize,
    input  wire logic [31:0]                    hwdata,
    input  wire logic                           hready,
    output logic      [31:0]                    hrdata,
    output logic                                hreadyout,
    output logic                                hresp,
    input  wire logic [mpdc_pkg::MPDC_SLOTS-1:0] slot_assigned,
    input  wire logic [mpdc_pkg::MPDC_SLOTS-1:0] slot_irq_state,
    output logic      [mpdc_pkg::MPDC_SLOTS-1:0] slot_drive_out,
    output logic      [mpdc_pkg::MPDC_SLOTS-1:0] slot_drive_oe,
    input  wire logic                           spi_mosi_int,
    input  wire logic                           spi_miso_pin,
    output logic                                spi_mosi_pin,
    output logic                                spi_miso_int,
    output logic                                spi_start,
    output logic      [7:0]                     spi_data_top_byte,
    input  wire logic                           s0_power,
    output logic                                io_bank_power_en,
    output logic                                io_bank_retain,
    output logic                                card_power_en
);
    import mpdc_pkg::*;

    logic       ap_valid_ff;
    logic       ap_write_ff;
    logic [7:0] ap_addr_ff;
    logic [7:0] spi_debug_ff;
    logic [7:0] always_on_power_control_ff;
    logic [2:0] s0_sync_ff;
    logic       s0_state_ff;
    logic [2:0] miso_sync_ff;
    logic       miso_state_ff;

    logic wr_debug;
    logic wr_power;
    logic wr_top;

    // Address phase capture; single cycle, no wait states
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_valid_ff <= 1'b0;
            ap_write_ff <= 1'b0;
            ap_addr_ff  <= 8'h00;
        end else if (hready) begin
            ap_valid_ff <= hsel && htrans[1];
            ap_write_ff <= hwrite;
            ap_addr_ff  <= haddr[7:0];
        end
    end

    assign wr_debug = ap_valid_ff && ap_write_ff && (ap_addr_ff == MPDC_OFF_SPI_DEBUG);
    assign wr_power = ap_valid_ff && ap_write_ff && (ap_addr_ff == MPDC_OFF_POWER);
    assign wr_top   = ap_valid_ff && ap_write_ff && (ap_addr_ff == MPDC_OFF_SPI_TOP);

    // Debug register follows platform reset as well as main reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            spi_debug_ff <= MPDC_RST_SPI_DEBUG;
        end else if (!plat_resetn) begin
            spi_debug_ff <= MPDC_RST_SPI_DEBUG;
        end else if (wr_debug) begin
            spi_debug_ff <= hwdata[7:0] & MPDC_MASK_SPI_DEBUG;
        end
    end

    // Always-on register ignores platform reset so it survives sleep
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            always_on_power_control_ff <= MPDC_RST_POWER;
        end else if (wr_power) begin
            always_on_power_control_ff <= hwdata[7:0] & MPDC_MASK_POWER;
        end
    end

    // Top data byte write doubles as the transfer trigger
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            spi_data_top_byte <= MPDC_RST_SPI_TOP;
            spi_start         <= 1'b0;
        end else begin
            spi_start <= wr_top;
            if (wr_top) begin
                spi_data_top_byte <= hwdata[7:0];
            end
        end
    end

    // Read data; unmapped offsets read as zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            unique case (haddr[7:0])
                MPDC_OFF_SPI_DEBUG: hrdata <= {24'h00_0000, spi_debug_ff};
                MPDC_OFF_POWER:     hrdata <= {24'h00_0000, always_on_power_control_ff};
                MPDC_OFF_SPI_TOP:   hrdata <= {24'h00_0000, spi_data_top_byte};
                default:            hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // Always ready, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // S0 and MISO pins come from outside; three stages, change when last two agree
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s0_sync_ff    <= 3'h0;
            s0_state_ff   <= 1'b0;
            miso_sync_ff  <= 3'h0;
            miso_state_ff <= 1'b0;
        end else begin
            s0_sync_ff   <= {s0_sync_ff[1:0], s0_power};
            miso_sync_ff <= {miso_sync_ff[1:0], spi_miso_pin};
            if (s0_sync_ff[1] == s0_sync_ff[2]) begin
                s0_state_ff <= s0_sync_ff[2];
            end
            if (miso_sync_ff[1] == miso_sync_ff[2]) begin
                miso_state_ff <= miso_sync_ff[2];
            end
        end
    end

    // Power switch enables; before S0 settles both rails follow their bits
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            io_bank_power_en <= 1'b0;
            io_bank_retain   <= 1'b0;
            card_power_en    <= 1'b1;
        end else begin
            io_bank_power_en <= s0_state_ff | always_on_power_control_ff[MPDC_BIT_IO_KEEP];
            io_bank_retain   <= always_on_power_control_ff[MPDC_BIT_IO_KEEP];
            card_power_en    <= s0_state_ff | ~always_on_power_control_ff[MPDC_BIT_CARD_OFF];
        end
    end

    // SPI path; loopback keeps the pin driven so the far device still sees data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            spi_mosi_pin <= 1'b0;
            spi_miso_int <= 1'b0;
        end else begin
            spi_mosi_pin <= spi_mosi_int;
            spi_miso_int <= spi_debug_ff[MPDC_BIT_LOOPBACK] ? spi_mosi_int : miso_state_ff;
        end
    end

    // Per-slot drive gating
    genvar gi;
    generate
        for (gi = 0; gi < MPDC_SLOTS; gi++) begin : g_slot
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    slot_drive_oe[gi]  <= 1'b0;
                    slot_drive_out[gi] <= 1'b0;
                end else begin
                    slot_drive_oe[gi]  <= spi_debug_ff[MPDC_BIT_SLOT_DRIVE] & slot_assigned[gi];
                    slot_drive_out[gi] <= slot_irq_state[gi];
                end
            end
        end
    endgenerate

    // Assertions
    property p_reserved_zero;
        @(posedge hclk) disable iff (!hresetn)
        ((spi_debug_ff & ~MPDC_MASK_SPI_DEBUG) == 8'h00) && ((always_on_power_control_ff & ~MPDC_MASK_POWER) == 8'h00);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

    property p_slot_off;
        @(posedge hclk) disable iff (!hresetn)
        !spi_debug_ff[MPDC_BIT_SLOT_DRIVE] |=> (slot_drive_oe == '0);
    endproperty
    a_slot_off: assert property (p_slot_off) else $error("slot driven while disabled");

    property p_slot_on;
        @(posedge hclk) disable iff (!hresetn)
        spi_debug_ff[MPDC_BIT_SLOT_DRIVE] |=>
            (slot_drive_oe == $past(slot_assigned)) && (slot_drive_out == $past(slot_irq_state));
    endproperty
    a_slot_on: assert property (p_slot_on) else $error("slot not driven with state");

    property p_loopback;
        @(posedge hclk) disable iff (!hresetn)
        spi_debug_ff[MPDC_BIT_LOOPBACK] |=>
            (spi_miso_int == $past(spi_mosi_int)) && (spi_mosi_pin == $past(spi_mosi_int));
    endproperty
    a_loopback: assert property (p_loopback) else $error("loopback path wrong");

    property p_aon_hold;
        @(posedge hclk) disable iff (!hresetn)
        !wr_power |=> $stable(always_on_power_control_ff);
    endproperty
    a_aon_hold: assert property (p_aon_hold) else $error("power register changed without write");

    property p_io_en;
        @(posedge hclk) disable iff (!hresetn)
        1'b1 |=> io_bank_power_en == ($past(s0_state_ff) | $past(always_on_power_control_ff[MPDC_BIT_IO_KEEP]));
    endproperty
    a_io_en: assert property (p_io_en) else $error("io bank enable wrong");

    property p_card_en;
        @(posedge hclk) disable iff (!hresetn)
        1'b1 |=> card_power_en == ($past(s0_state_ff) | ~$past(always_on_power_control_ff[MPDC_BIT_CARD_OFF]));
    endproperty
    a_card_en: assert property (p_card_en) else $error("card enable wrong");

    property p_start;
        @(posedge hclk) disable iff (!hresetn)
        wr_top |=> spi_start ##1 !spi_start || $past(wr_top);
    endproperty
    a_start: assert property (p_start) else $error("no transfer start");

    property p_plat_clear;
        @(posedge hclk) disable iff (!hresetn)
        !plat_resetn |=> (spi_debug_ff == 8'h00);
    endproperty
    a_plat_clear: assert property (p_plat_clear) else $error("debug register not cleared");

    // Bus answer never stalls and never errors, so masters need no retry path
    property p_bus_okay;
        @(posedge hclk) disable iff (!hresetn)
        hreadyout && !hresp;
    endproperty
    a_bus_okay: assert property (p_bus_okay) else $error("bus answer not ready or not okay");

    // Only the low byte carries register data
    property p_read_upper_zero;
        @(posedge hclk) disable iff (!hresetn)
        hrdata[31:8] == 24'h00_0000;
    endproperty
    a_read_upper_zero: assert property (p_read_upper_zero) else $error("upper read bits set");

    // Writes keep only the defined bits; platform reset takes priority
    property p_debug_write;
        @(posedge hclk) disable iff (!hresetn)
        wr_debug && plat_resetn |=> spi_debug_ff == ($past(hwdata[7:0]) & MPDC_MASK_SPI_DEBUG);
    endproperty
    a_debug_write: assert property (p_debug_write) else $error("debug write lost");

    // Platform reset must not block a write to the always-on register
    property p_power_write;
        @(posedge hclk) disable iff (!hresetn)
        wr_power |=> always_on_power_control_ff == ($past(hwdata[7:0]) & MPDC_MASK_POWER);
    endproperty
    a_power_write: assert property (p_power_write) else $error("power write lost");

    property p_retain;
        @(posedge hclk) disable iff (!hresetn)
        1'b1 |=> io_bank_retain == $past(always_on_power_control_ff[MPDC_BIT_IO_KEEP]);
    endproperty
    a_retain: assert property (p_retain) else $error("retain flag wrong");

    // Loopback off: receive path comes from the filtered pin
    property p_spi_normal;
        @(posedge hclk) disable iff (!hresetn)
        !spi_debug_ff[MPDC_BIT_LOOPBACK] |=> spi_miso_int == $past(miso_state_ff);
    endproperty
    a_spi_normal: assert property (p_spi_normal) else $error("normal receive path wrong");

    property p_start_only;
        @(posedge hclk) disable iff (!hresetn)
        !wr_top |=> !spi_start;
    endproperty
    a_start_only: assert property (p_start_only) else $error("transfer start without write");

    property p_top_byte;
        @(posedge hclk) disable iff (!hresetn)
        wr_top |=> spi_data_top_byte == $past(hwdata[7:0]);
    endproperty
    a_top_byte: assert property (p_top_byte) else $error("top data byte not stored");

    // A pin level that has not settled must not reach the power enables
    property p_s0_filter;
        @(posedge hclk) disable iff (!hresetn)
        s0_sync_ff[1] != s0_sync_ff[2] |=> $stable(s0_state_ff);
    endproperty
    a_s0_filter: assert property (p_s0_filter) else $error("unsettled S0 level taken");
endmodule : mpdc_top

// >>> rtl/mpdc_pkg.sv
// Package of offsets, field positions and reset values for the power and debug control bank
package mpdc_pkg;
    // Register byte offsets
    localparam logic [7:0] MPDC_OFF_SPI_DEBUG = 8'h00;
    localparam logic [7:0] MPDC_OFF_POWER     = 8'h04;
    localparam logic [7:0] MPDC_OFF_SPI_TOP   = 8'h08;
    // Field positions
    localparam int MPDC_BIT_SLOT_DRIVE = 2;
    localparam int MPDC_BIT_LOOPBACK   = 1;
    localparam int MPDC_BIT_IO_KEEP    = 1;
    localparam int MPDC_BIT_CARD_OFF   = 0;
    // Writable masks, reserved bits excluded
    localparam logic [7:0] MPDC_MASK_SPI_DEBUG = 8'h06;
    localparam logic [7:0] MPDC_MASK_POWER     = 8'h03;
    // Reset values
    localparam logic [7:0] MPDC_RST_SPI_DEBUG = 8'h00;
    localparam logic [7:0] MPDC_RST_POWER     = 8'h00;
    localparam logic [7:0] MPDC_RST_SPI_TOP   = 8'h00;
    // Serial interrupt slot count
    localparam int MPDC_SLOTS = 16;
endpackage : mpdc_pkg

// >>> test/mpdc_far_side.sv
// Far-side model: shared serial interrupt slot wires and a foreign SPI data line
`timescale 1ns/1ps
module mpdc_far_side (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        spi_mosi_pin,
    input  wire logic [15:0] slot_drive_out,
    input  wire logic [15:0] slot_drive_oe,
    output logic      [15:0] slot_wire,
    output logic             spi_miso_pin
);
    // Pull-up holds any slot the device releases high, free for others
    assign slot_wire = (slot_drive_out & slot_drive_oe) | ~slot_drive_oe;
    // Far device answers with the inverse of what it hears, so loopback and normal paths differ
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            spi_miso_pin <= 1'b0;
        end else begin
            spi_miso_pin <= ~spi_mosi_pin;
        end
    end
endmodule : mpdc_far_side

// >>> test/mpdc_top_test.sv
// Self-checking bench for the power and debug control bank
`timescale 1ns/1ps
module mpdc_top_test;
    import mpdc_pkg::*;
    typedef struct packed {logic [7:0] dw; logic [7:0] pw; logic s0;} mpdc_row_t;
    localparam mpdc_row_t ROWS [6] = '{'{8'hFF, 8'hFF, 1'b0}, '{8'h00, 8'h00, 1'b0}, '{8'hF9, 8'hFC, 1'b1},
                                     '{8'h04, 8'h01, 1'b1}, '{8'h02, 8'h02, 1'b0}, '{8'h04, 8'h01, 1'b0}};
    logic        hclk = 1'b0, hresetn = 1'b0, plat_resetn = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic [1:0]  htrans = 2'b00;
    logic        hreadyout, hresp, spi_mosi_int = 1'b0, spi_miso_pin, spi_mosi_pin, spi_miso_int, spi_start;
    logic [15:0] slot_assigned = 16'hA5A5, slot_irq_state = '0, slot_drive_out, slot_drive_oe, slot_wire;
    logic [7:0]  spi_data_top_byte;
    logic        s0_power = 1'b0, io_bank_power_en, io_bank_retain, card_power_en;
    int          num_errors = 0, num_checks = 0;
    // Half period of 2.5 ns gives 200 MHz
    always #2.5 hclk = ~hclk;
    mpdc_top i_mpdc_top (.hclk(hclk), .hresetn(hresetn), .plat_resetn(plat_resetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .slot_assigned(slot_assigned), .slot_irq_state(slot_irq_state),
        .slot_drive_out(slot_drive_out), .slot_drive_oe(slot_drive_oe), .spi_mosi_int(spi_mosi_int),
        .spi_miso_pin(spi_miso_pin), .spi_mosi_pin(spi_mosi_pin), .spi_miso_int(spi_miso_int),
        .spi_start(spi_start), .spi_data_top_byte(spi_data_top_byte), .s0_power(s0_power),
        .io_bank_power_en(io_bank_power_en), .io_bank_retain(io_bank_retain), .card_power_en(card_power_en));
    mpdc_far_side i_mpdc_far_side (.hclk(hclk), .hresetn(hresetn), .slot_drive_out(slot_drive_out),
        .slot_drive_oe(slot_drive_oe), .slot_wire(slot_wire), .spi_miso_pin(spi_miso_pin), .spi_mosi_pin(spi_mosi_pin));
    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wrap_up();
        if (num_errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up
    // Single AHB-Lite transfer, held until hready seen high at each phase
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        htrans <= 2'b10;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask : ahb
    // Watchdog sized well beyond the expected run
    initial begin
        repeat (20000) @(posedge hclk);
        num_errors++;
        wrap_up();
    end
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, MPDC_OFF_SPI_DEBUG, '0);
        chk(rd, 32'h0);
        ahb(1'b0, MPDC_OFF_POWER, '0);
        chk(rd, 32'h0);
        chk({io_bank_power_en, card_power_en, slot_drive_oe}, {2'b01, 16'h0000});
        // Table of writes, s0 level, interrupt pattern and loopback source
        foreach (ROWS[i]) begin
            s0_power <= ROWS[i].s0;
            slot_irq_state <= {ROWS[i].pw, ROWS[i].dw};
            spi_mosi_int <= ROWS[i].dw[0];
            ahb(1'b1, MPDC_OFF_SPI_DEBUG, {24'hFFFFFF, ROWS[i].dw});
            ahb(1'b1, MPDC_OFF_POWER, {24'hFFFFFF, ROWS[i].pw});
            repeat (8) @(posedge hclk);
            ahb(1'b0, MPDC_OFF_SPI_DEBUG, '0);
            chk(rd, {24'h0, ROWS[i].dw & MPDC_MASK_SPI_DEBUG});
            ahb(1'b0, MPDC_OFF_POWER, '0);
            chk(rd, {24'h0, ROWS[i].pw & MPDC_MASK_POWER});
            chk(io_bank_power_en, ROWS[i].s0 | ROWS[i].pw[1]);
            chk(card_power_en, {ROWS[i].s0 | ~ROWS[i].pw[0]});
            if (!ROWS[i].s0) chk(io_bank_retain, ROWS[i].pw[1]);
            chk(slot_drive_oe, ROWS[i].dw[2] ? slot_assigned : 16'h0);
            chk(slot_wire, ROWS[i].dw[2] ? {slot_irq_state | ~slot_assigned} : 16'hFFFF);
            chk(spi_mosi_pin, ROWS[i].dw[0]);
            chk(spi_miso_int, {ROWS[i].dw[1] ? ROWS[i].dw[0] : ~ROWS[i].dw[0]});
        end
        // Unmapped address reads zero
        ahb(1'b1, 8'h0C, 32'hFF);
        chk({hresp, hreadyout}, 2'b01);
        ahb(1'b0, 8'h0C, '0);
        chk(rd, 32'h0);
        // Top byte write under loopback starts a transfer, one-cycle pulse
        ahb(1'b1, MPDC_OFF_SPI_DEBUG, 32'h02);
        ahb(1'b1, MPDC_OFF_SPI_TOP, 32'h5A);
        #1;
        chk({spi_start, spi_data_top_byte}, {1'b1, 8'h5A});
        @(posedge hclk);
        #1;
        chk(spi_start, 1'b0);
        // Platform reset clears the debug register only
        ahb(1'b1, MPDC_OFF_POWER, 32'h03);
        @(posedge hclk);
        plat_resetn <= 1'b0;
        @(posedge hclk);
        plat_resetn <= 1'b1;
        ahb(1'b0, MPDC_OFF_SPI_DEBUG, '0);
        chk(rd, 32'h0);
        ahb(1'b0, MPDC_OFF_POWER, '0);
        chk(rd, 32'h3);
        // Main reset in mid-run clears the power register
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, MPDC_OFF_POWER, '0);
        chk(rd, 32'h0);
        wrap_up();
    end
endmodule : mpdc_top_test
